// *** clk_cfg_map.svh ***
// register offsets, field positions, reset values and clock figures for the clock config block
// assumes a 32-bit classic wishbone slave with word addresses at byte offsets
`ifndef CLK_CFG_MAP_SVH
`define CLK_CFG_MAP_SVH

// ----------------------------------------
// offsets
// ----------------------------------------
`define RUN_CLOCK_CONFIG_OFS    8'h60
`define SECOND_CLOCK_CONFIG_OFS 8'h70
`define PLL_STATUS_OFS          8'h74

// ----------------------------------------
// run config fields
// ----------------------------------------
`define RCFG_DIV_HI      26
`define RCFG_DIV_LO      23
`define RCFG_DIVEN_BIT   22
`define RCFG_PDOWN_BIT   13
`define RCFG_ONE_BIT     12
`define RCFG_BYPASS_BIT  11
`define RCFG_CRYSTAL_HI  9
`define RCFG_CRYSTAL_LO  6
`define RCFG_WR_MASK     32'h07C02BC0
`define RCFG_FIXED_ONES  32'h00001000
`define RCFG_RESET       32'h07803AC0

// ----------------------------------------
// second config fields
// ----------------------------------------
`define SCFG_USE_BIT     31
`define SCFG_DIV_HI      28
`define SCFG_DIV_LO      23
`define SCFG_WR_MASK     32'h9F800000
`define SCFG_RESET       32'h07C00000

// ----------------------------------------
// timing
// ----------------------------------------
`define PLL_TARGET_MHZ   400
`define REF_CLK_MHZ      40
`define PLL_LOCK_US      1
`define PLL_LOCK_CYCLES  (`PLL_LOCK_US * `REF_CLK_MHZ)
`define CRYSTAL_MIN_PLL  4'h4

`endif

// *** clk_cfg_pkg.sv ***
// types for the run-mode clock config block
// assumes the map header is included where constants are needed
`default_nettype none
package clk_cfg_pkg;
  typedef struct packed {
    logic       bypass;
    logic       pll_power_down;
    logic [5:0] divisor;
    logic       divide;
    logic [3:0] crystal_select;
  } clk_ctrl_t;

  typedef enum logic [1:0] {
    PLL_OFF  = 2'b00,
    PLL_WAIT = 2'b01,
    PLL_LOCK = 2'b10
  } pll_state_t;
endpackage : clk_cfg_pkg
`default_nettype wire

// *** pll_lock_timer.sv ***
// pll lock timer: counts settling cycles after power-up
// assumes power_down is a same-clock register output
`include "clk_cfg_map.svh"
`default_nettype none
module pll_lock_timer
  import clk_cfg_pkg::*;
(
  input  wire logic clk_in,
  input  wire logic rst_b_in,
  input  wire logic power_down_in,
  output var  logic locked_out
);
  pll_state_t  state_ff, nxt_state;
  logic [15:0] cnt_ff,   nxt_cnt;
  wire         done = (cnt_ff == 16'(`PLL_LOCK_CYCLES - 1));

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt   = 16'h0000;
    case (state_ff)
      PLL_OFF:  if (!power_down_in) nxt_state = PLL_WAIT;
      PLL_WAIT: begin
        nxt_cnt = cnt_ff + 16'h0001;
        if (power_down_in) nxt_state = PLL_OFF;
        else if (done)     nxt_state = PLL_LOCK;
      end
      PLL_LOCK: if (power_down_in) nxt_state = PLL_OFF;
      default:  nxt_state = PLL_OFF;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      state_ff <= PLL_OFF;
      cnt_ff   <= 16'h0000;
    end else begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
    end
  end

  assign locked_out = (state_ff == PLL_LOCK);
endmodule : pll_lock_timer
`default_nettype wire

// *** rcc_asserts.sv ***
// checker for the run clock config block
// assumes it is bound to the top module ports
`include "clk_cfg_map.svh"
`default_nettype none
module run_cfg_asserts (
  input wire logic        REF_CLK_IN,
  input wire logic        RST_B_IN,
  input wire logic        WB_CYC_IN,
  input wire logic        WB_STB_IN,
  input wire logic        WB_WE_IN,
  input wire logic [7:0]  WB_ADR_IN,
  input wire logic [31:0] WB_DAT_OUT,
  input wire logic        WB_ACK_OUT,
  input wire logic        WB_ERR_OUT,
  input wire logic        PLL_POWER_DOWN_OUT,
  input wire logic [3:0]  CRYSTAL_SELECT_OUT,
  input wire logic        SYSCLK_USE_PLL_OUT,
  input wire logic        SYSCLK_DIVIDE_OUT
);
  // ----------------------------------------
  // bus and field checks
  // ----------------------------------------
  default clocking @(posedge REF_CLK_IN); endclocking
  default disable iff (!RST_B_IN);
  // outputs lag the stored field by one edge, as the readback does; the checks look two cycles on
  sequence run_rd;
    WB_ACK_OUT && !WB_WE_IN && WB_ADR_IN == `RUN_CLOCK_CONFIG_OFS;
  endsequence
  a_ack_pulse: assert property (
    WB_ACK_OUT |=> !WB_ACK_OUT)
    else $error("ack held too long");
  a_take_answer: assert property (
    $rose(WB_STB_IN) && WB_CYC_IN |=> WB_ACK_OUT || WB_ERR_OUT)
    else $error("no answer");
  a_err_alone: assert property (
    WB_ERR_OUT |-> !WB_ACK_OUT ##1 !WB_ERR_OUT)
    else $error("bad error pulse");
  a_rsvd_fixed: assert property (
    run_rd |-> WB_DAT_OUT[21:14] == 8'h00 && WB_DAT_OUT[12] && !WB_DAT_OUT[10])
    else $error("reserved bits wrong");
  a_pdown_drive: assert property (
    run_rd |-> ##2 PLL_POWER_DOWN_OUT == $past(WB_DAT_OUT[13], 2))
    else $error("power down pin mismatch");
  a_crystal_drive: assert property (
    run_rd |-> ##2 CRYSTAL_SELECT_OUT == $past(WB_DAT_OUT[9:6], 2))
    else $error("crystal pin mismatch");
  a_bypass_src: assert property (
    run_rd |-> ##2 SYSCLK_USE_PLL_OUT == !$past(WB_DAT_OUT[11], 2))
    else $error("clock source mismatch");
  a_pll_divides: assert property (
    SYSCLK_USE_PLL_OUT |-> SYSCLK_DIVIDE_OUT)
    else $error("pll without divider");
endmodule : run_cfg_asserts
`default_nettype wire

// *** run_clock_config.sv ***
// run-mode clock config registers on a classic wishbone slave
// assumes one clock, synchronous active-low reset, 32-bit aligned word accesses
//
// Operation
// [RL1] second config overrides divisor when enabled
// [RL2] bits 21:14 read zero, fixed
// [RL3] bit 13 powers down pll, resets one
// [RL4] bit 11 bypass selects oscillator, resets one
// [RL5] bypass clear: pll output divided
// [RL6] software keeps adc clock 14-18 MHz
// [RL7] bits 9:6 crystal select, reset 0xB
// [RL8] software avoids low crystal codes with pll
// [RL9] pll aims at 400 MHz output
// [RL10] bit 12 reads one, bit 10 zero
// [RL11] pll source forces system divider
// [RL12] reserved bits ignore writes, read fixed
//
// The Wishbone register port and the address map were left to the implementer.
`include "clk_cfg_map.svh"
`default_nettype none
module run_clock_config
  import clk_cfg_pkg::*;
(
  input  wire logic        REF_CLK_IN,
  input  wire logic        RST_B_IN,
  input  wire logic        WB_CYC_IN,
  input  wire logic        WB_STB_IN,
  input  wire logic        WB_WE_IN,
  input  wire logic [7:0]  WB_ADR_IN,
  input  wire logic [3:0]  WB_SEL_IN,
  input  wire logic [31:0] WB_DAT_IN,
  output logic      [31:0] WB_DAT_OUT,
  output logic             WB_ACK_OUT,
  output logic             WB_ERR_OUT,
  output logic             PLL_POWER_DOWN_OUT,
  output logic      [3:0]  CRYSTAL_SELECT_OUT,
  output logic             SYSCLK_USE_PLL_OUT,
  output logic             SYSCLK_DIVIDE_OUT,
  output logic      [5:0]  SYSCLK_DIVISOR_OUT,
  output logic             PLL_LOCKED_OUT
);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] sel, input logic [31:0] wmask);
    logic [31:0] lanes;
    lanes = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}} & wmask;
    merge = (old & ~lanes) | (wd & lanes);
  endfunction : merge

  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  logic [31:0] run_cfg_ff,  nxt_run_cfg;
  logic [31:0] sec_cfg_ff,  nxt_sec_cfg;
  logic        ack_ff;
  logic        err_ff;
  logic [31:0] rdata_ff;
  logic        locked;
  logic        locked_ff;
  logic [5:0]  eff_div;
  logic        use_pll;
  logic        divide;

  wire req       = WB_CYC_IN & WB_STB_IN & ~ack_ff & ~err_ff;
  wire hit_run   = (WB_ADR_IN == `RUN_CLOCK_CONFIG_OFS);
  wire hit_sec   = (WB_ADR_IN == `SECOND_CLOCK_CONFIG_OFS);
  wire hit_stat  = (WB_ADR_IN == `PLL_STATUS_OFS);
  wire hit_any   = hit_run | hit_sec | hit_stat;
  wire wr_run    = req & WB_WE_IN & hit_run;
  wire wr_sec    = req & WB_WE_IN & hit_sec;

  // [RL12] masked writes only
  assign nxt_run_cfg = wr_run ? merge(run_cfg_ff, WB_DAT_IN, WB_SEL_IN, `RCFG_WR_MASK)
                              : run_cfg_ff;
  assign nxt_sec_cfg = wr_sec ? merge(sec_cfg_ff, WB_DAT_IN, WB_SEL_IN, `SCFG_WR_MASK)
                              : sec_cfg_ff;

  // [RL2] fixed reserved readback
  // [RL10] bit 12 forced one
  wire [31:0] run_view = (run_cfg_ff & `RCFG_WR_MASK) | `RCFG_FIXED_ONES;
  wire [31:0] rd_mux   = hit_run  ? run_view :
                         hit_sec  ? (sec_cfg_ff & `SCFG_WR_MASK) :
                         hit_stat ? {31'h00000000, locked_ff} : 32'h00000000;

  // ----------------------------------------
  // control fields
  // ----------------------------------------
  wire use_second = sec_cfg_ff[`SCFG_USE_BIT];
  // [RL1] alternate divisor override
  wire [5:0] div_sel = use_second ? sec_cfg_ff[`SCFG_DIV_HI:`SCFG_DIV_LO]
                                  : {2'h0, run_cfg_ff[`RCFG_DIV_HI:`RCFG_DIV_LO]};
  clk_ctrl_t ctrl;
  // [RL3] power-down drives pll
  // [RL7] crystal code to pll
  assign ctrl = '{bypass:         run_cfg_ff[`RCFG_BYPASS_BIT],
                  pll_power_down: run_cfg_ff[`RCFG_PDOWN_BIT],
                  divisor:        div_sel,
                  divide:         run_cfg_ff[`RCFG_DIVEN_BIT],
                  crystal_select: run_cfg_ff[`RCFG_CRYSTAL_HI:`RCFG_CRYSTAL_LO]};

  sysclk_select u_sel (
    .clk_in      (REF_CLK_IN),
    .rst_b_in    (RST_B_IN),
    .ctrl_in     (ctrl),
    .divisor_out (eff_div),
    .use_pll_out (use_pll),
    .divide_out  (divide)
  );

  // [RL9] lock models 400 MHz pll settle
  pll_lock_timer u_lock (
    .clk_in        (REF_CLK_IN),
    .rst_b_in      (RST_B_IN),
    .power_down_in (ctrl.pll_power_down),
    .locked_out    (locked)
  );

  // ----------------------------------------
  // registers
  // ----------------------------------------
  // single-cycle ack: one wait state after the request edge keeps outputs registered
  always_ff @(posedge REF_CLK_IN) begin
    if (!RST_B_IN) begin
      run_cfg_ff <= `RCFG_RESET;
      sec_cfg_ff <= `SCFG_RESET;
      ack_ff     <= 1'b0;
      err_ff     <= 1'b0;
      rdata_ff   <= 32'h00000000;
      locked_ff  <= 1'b0;
    end else begin
      run_cfg_ff <= nxt_run_cfg;
      sec_cfg_ff <= nxt_sec_cfg;
      ack_ff     <= req & hit_any;
      err_ff     <= req & ~hit_any;
      rdata_ff   <= (req & hit_any) ? rd_mux : 32'h00000000;
      locked_ff  <= locked;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  always_ff @(posedge REF_CLK_IN) begin
    if (!RST_B_IN) begin
      PLL_POWER_DOWN_OUT <= 1'b1;
      CRYSTAL_SELECT_OUT <= 4'hB;
    end else begin
      PLL_POWER_DOWN_OUT <= ctrl.pll_power_down;
      CRYSTAL_SELECT_OUT <= ctrl.crystal_select;
    end
  end

  assign WB_ACK_OUT         = ack_ff;
  assign WB_ERR_OUT         = err_ff;
  assign WB_DAT_OUT         = rdata_ff;
  assign SYSCLK_USE_PLL_OUT = use_pll;
  assign SYSCLK_DIVIDE_OUT  = divide;
  assign SYSCLK_DIVISOR_OUT = eff_div;
  assign PLL_LOCKED_OUT     = locked_ff;
endmodule : run_clock_config
`default_nettype wire

// *** run_clock_config_tb.sv ***
// self-checking bench for the run clock config block
// assumes a 40 MHz clock and full-word accesses apart from one low-byte-lane write
`include "clk_cfg_map.svh"
`default_nettype none
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin n_mismatch++; \
  $display("MISMATCH t=%0t got %h exp %h", $time, a, e); end end
module run_clock_config_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // stimulus and scenarios
  // ----------------------------------------
  logic        clk = 1'b0, rst_b = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h0, dout, q;
  logic        ack, err, pdown, use_pll, divide, e, locked;
  logic [3:0]  crystal, sel = 4'hF;
  logic [5:0]  divisor;
  int          n_mismatch = 0;
  int          num_checks = 0;
  localparam logic [7:0] RUN = `RUN_CLOCK_CONFIG_OFS;
  localparam logic [7:0] SEC = `SECOND_CLOCK_CONFIG_OFS;
  localparam logic [7:0] STAT = `PLL_STATUS_OFS;
  always #12.5 clk = ~clk;
  run_clock_config i_run_clock_config (.REF_CLK_IN(clk), .RST_B_IN(rst_b), .WB_CYC_IN(cyc),
    .WB_STB_IN(stb), .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(sel), .WB_DAT_IN(wdat),
    .WB_DAT_OUT(dout), .WB_ACK_OUT(ack), .WB_ERR_OUT(err), .PLL_POWER_DOWN_OUT(pdown),
    .CRYSTAL_SELECT_OUT(crystal), .SYSCLK_USE_PLL_OUT(use_pll), .SYSCLK_DIVIDE_OUT(divide),
    .SYSCLK_DIVISOR_OUT(divisor), .PLL_LOCKED_OUT(locked));
  // waits for ack or err, then leaves two edges for the outputs to follow
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
    do @(posedge clk); while (ack !== 1'b1 && err !== 1'b1);
    q = dout;
    e = err;
    {cyc, stb} <= 2'b00;
    repeat (2) @(posedge clk);
  endtask : wb
  task automatic t_reset;
    wb(1'b0, RUN, 32'h00000000);
    `CHK(q, `RCFG_RESET)
    `CHK({pdown, use_pll, crystal}, 6'h2B)
    `CHK({divide, divisor, locked}, 8'h1E)
    wb(1'b0, SEC, 32'h00000000);
    `CHK(q, 32'h07800000)
  endtask : t_reset
  task automatic t_rsvd;
    wb(1'b1, RUN, 32'hFFFFFFFF);
    wb(1'b0, RUN, 32'h00000000);
    `CHK(q, 32'h07C03BC0)
    `CHK({use_pll, crystal}, 5'h0F)
    // code 0x4 is legal with the pll
    wb(1'b1, RUN, 32'h00000100);
    wb(1'b0, RUN, 32'h00000000);
    `CHK(q, 32'h00001100)
    `CHK({pdown, use_pll, divide}, 3'b011)
  endtask : t_rsvd
  task automatic t_divisor;
    wb(1'b1, RUN, 32'h02800180);
    `CHK({divisor, crystal}, 10'h056)
    wb(1'b1, SEC, 32'hFFFFFFFF);
    wb(1'b0, SEC, 32'h00000000);
    `CHK(q, 32'h9F800000)
    `CHK(divisor, 6'h3F)
    wb(1'b1, SEC, 32'h95000000);
    `CHK(divisor, 6'h2A)
    wb(1'b1, SEC, 32'h15000000);
    `CHK(divisor, 6'h05)
    wb(1'b1, RUN, 32'h00002800);
    `CHK({use_pll, divide, divisor}, 8'h00)
  endtask : t_divisor
  task automatic t_unmapped;
    wb(1'b1, 8'h64, 32'hFFFFFFFF);
    `CHK(e, 1'b1)
    wb(1'b0, RUN, 32'h00000000);
    `CHK(q, 32'h00003800)
    sel <= 4'h1;
    wb(1'b1, RUN, 32'hFFFFFFFF);
    sel <= 4'hF;
    wb(1'b0, RUN, 32'h00000000);
    `CHK(q, 32'h000038C0)
    `CHK(crystal, 4'h3)
  endtask : t_unmapped
  // lock seen by the bench 2 edges after the timer ends its count
  task automatic t_lock;
    wb(1'b1, RUN, 32'h000002C0);
    `CHK(locked, 1'b0)
    repeat (`PLL_LOCK_CYCLES - 1) @(posedge clk);
    `CHK(locked, 1'b0)
    @(posedge clk);
    `CHK(locked, 1'b1)
    wb(1'b0, STAT, 32'h00000000);
    `CHK(q, 32'h00000001)
  endtask : t_lock
  task automatic t_midreset;
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    t_reset();
  endtask : t_midreset
  task automatic tally_and_finish;
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    t_reset();
    t_rsvd();
    t_divisor();
    t_unmapped();
    t_lock();
    t_midreset();
    tally_and_finish();
  end
  // whole run is near 150 cycles, so this only fires on a hang
  initial begin
    repeat (3000) @(posedge clk);
    n_mismatch++;
    tally_and_finish();
  end
endmodule : run_clock_config_tb
bind run_clock_config run_cfg_asserts i_run_cfg_asserts (.REF_CLK_IN, .RST_B_IN, .WB_CYC_IN,
  .WB_STB_IN, .WB_WE_IN, .WB_ADR_IN, .WB_DAT_OUT, .WB_ACK_OUT, .WB_ERR_OUT,
  .PLL_POWER_DOWN_OUT, .CRYSTAL_SELECT_OUT, .SYSCLK_USE_PLL_OUT, .SYSCLK_DIVIDE_OUT);
`default_nettype wire

// *** sysclk_select.sv ***
// picks the effective divisor and clock source from the control fields
// assumes inputs are same-clock register outputs
`include "clk_cfg_map.svh"
`default_nettype none
module sysclk_select
  import clk_cfg_pkg::*;
(
  input  wire logic      clk_in,
  input  wire logic      rst_b_in,
  input  wire clk_ctrl_t ctrl_in,
  output var  logic [5:0] divisor_out,
  output var  logic       use_pll_out,
  output var  logic       divide_out
);
  wire use_pll = ~ctrl_in.bypass;
  // [RL11] pll forces divider
  wire divide  = use_pll | ctrl_in.divide;

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      divisor_out <= 6'h1F;
      use_pll_out <= 1'b0;
      divide_out  <= 1'b0;
    end else begin
      divisor_out <= ctrl_in.divisor;
      // [RL4] bypass picks oscillator
      use_pll_out <= use_pll;
      // [RL5] pll output divided
      divide_out  <= divide;
    end
  end
endmodule : sysclk_select
`default_nettype wire
